// ===== core/bit_toggle_branch_skip_pkg.sv
// shared constants, types and helpers for the toggle, branch and skip execute block
package bit_toggle_branch_skip_pkg;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned PC_W = 21;

	// opcode patterns in the fetched word
	localparam logic [3:0] TOGGLE_PATTERN = 4'h7;
	localparam logic [7:0] OVF_BRANCH_PATTERN = 8'he4;
	localparam logic [5:0] INC_SKIP_Z_PATTERN = 6'h0f;
	localparam logic [5:0] INC_SKIP_NZ_PATTERN = 6'h12;

	// operand addressing
	localparam logic [7:0] INDEXED_F_MAX = 8'h5f;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

	// register map, byte addresses
	localparam logic [11:0] CTRL_OFFSET = 12'h000;
	localparam logic [11:0] BANK_OFFSET = 12'h004;
	localparam logic [11:0] FLAGS_OFFSET = 12'h008;
	localparam logic [11:0] WREG_OFFSET = 12'h00c;
	localparam logic [11:0] PC_OFFSET = 12'h010;
	localparam logic [11:0] INDEX_BASE_OFFSET = 12'h014;
	localparam logic [11:0] CYCLES_OFFSET = 12'h018;

	localparam int unsigned CTRL_RUN_BIT = 0;
	localparam int unsigned CTRL_EXT_BIT = 1;
	localparam int unsigned FLAG_OV_BIT = 3;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] WREG_RESET = 8'h00;
	localparam logic [3:0] BANK_RESET = 4'h0;
	localparam logic [11:0] INDEX_BASE_RESET = 12'h000;
	localparam logic [1:0] CYCLES_RESET = 2'h0;

	typedef enum logic [3:0] {
		ST_HALT = 4'b0001,
		ST_FETCH = 4'b0010,
		ST_READ = 4'b0100,
		ST_WRITE = 4'b1000
	} state_type;
	localparam int unsigned FETCH_BIT = 1;

	typedef enum logic [4:0] {
		K_OTHER = 5'b00001,
		K_TOGGLE = 5'b00010,
		K_BOV = 5'b00100,
		K_INCZ = 5'b01000,
		K_INCNZ = 5'b10000
	} op_kind_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic we;
	} dmem_req_type;

	function automatic op_kind_type classify(input logic [WORD_W-1:0] w);
		if (w[15:12] == TOGGLE_PATTERN) return K_TOGGLE;
		if (w[15:8] == OVF_BRANCH_PATTERN) return K_BOV;
		if (w[15:10] == INC_SKIP_Z_PATTERN) return K_INCZ;
		if (w[15:10] == INC_SKIP_NZ_PATTERN) return K_INCNZ;
		return K_OTHER;
	endfunction

	// first words of the two-word instructions
	function automatic logic is_two_word(input logic [WORD_W-1:0] w);
		return (w[15:12] == 4'hc) || (w[15:9] == 7'h76) || (w[15:8] == 8'hef) ||
			(w[15:8] == 8'hee);
	endfunction
endpackage

// ===== core/operand_addr_resolve.sv
// resolves the data memory address of a register operand
`timescale 1ns/1ps
`default_nettype none
module operand_addr_resolve (
	// operand fields
	input wire logic [7:0] f_i,
	input wire logic access_i,
	// addressing context
	input wire logic ext_en_i,
	input wire logic [3:0] bank_i,
	input wire logic [11:0] index_base_i,
	// result
	output logic [11:0] addr_o,
	output logic indexed_o
);
	import bit_toggle_branch_skip_pkg::*;

	always_comb begin
		indexed_o = ext_en_i && !access_i && (f_i <= INDEXED_F_MAX);
		if (indexed_o) begin
			addr_o = index_base_i + {4'h0, f_i};
		end else if (!access_i) begin
			addr_o = (f_i < ACCESS_SPLIT) ? {ACCESS_LOW_BANK, f_i} : {ACCESS_HIGH_BANK, f_i};
		end else begin
			addr_o = {bank_i, f_i};
		end
	end
endmodule
`default_nettype wire

// ===== core/bit_toggle_branch_skip_exec.sv
// execute block for bit toggle, overflow branch and increment-and-skip instructions
// Contract
// - toggle inverts bit b of f, flags kept
// - taken overflow branch sets pc+2+2n, flags kept
// - branch decoded by e4 high byte, signed offset
// - increment f; d=0 to wreg, d=1 to f
// - zero result discards next fetched word
// - nonzero result discards next fetched word
// - a=0, extended set, f<=5f uses indexed addressing
// - indexed addressing only when extended config set
`timescale 1ns/1ps
`default_nettype none
module bit_toggle_branch_skip_exec #(
	parameter int unsigned PC_WIDTH = bit_toggle_branch_skip_pkg::PC_W
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// instruction fetch stream
	input wire logic fetch_valid_i,
	input wire logic [bit_toggle_branch_skip_pkg::WORD_W-1:0] fetch_word_i,
	output logic fetch_ready_o,
	output logic [PC_WIDTH-1:0] pc_o,
	// data memory
	output bit_toggle_branch_skip_pkg::dmem_req_type dmem_o,
	input wire logic [bit_toggle_branch_skip_pkg::DATA_W-1:0] dmem_rdata_i
);
	import bit_toggle_branch_skip_pkg::*;

	state_type state;
	op_kind_type kind_q;
	op_kind_type next_kind;
	logic [WORD_W-1:0] instr;
	logic [7:0] rdata;
	logic [7:0] wreg;
	logic [7:0] flags;
	logic [3:0] bank;
	logic [11:0] index_base;
	logic run;
	logic ext_en;
	logic [1:0] drop_cnt;
	logic drop_may_extend;
	logic [1:0] cyc_cur;
	logic [1:0] cyc_last;
	logic [11:0] res_addr;
	logic res_indexed;
	logic take, issue, drop;
	logic apb_wr, apb_rd_phase;
	logic [7:0] inc_result;
	logic skip;
	logic bov_taken;
	logic [PC_WIDTH-1:0] bov_target;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (reset_i);

	logic [PC_WIDTH-1:0] pc_q;
	assign fetch_ready_o = state[FETCH_BIT];
	assign pc_o = pc_q;

	assign take = fetch_ready_o && fetch_valid_i;
	assign issue = take && (drop_cnt == 2'h0);
	assign drop = take && (drop_cnt != 2'h0);
	assign next_kind = classify(fetch_word_i);
	assign inc_result = rdata + 8'h01;
	assign skip = ((kind_q == K_INCZ) && (inc_result == 8'h00)) ||
		((kind_q == K_INCNZ) && (inc_result != 8'h00));
	assign bov_taken = issue && (next_kind == K_BOV) && flags[FLAG_OV_BIT];
	// signed word offset, doubled, added to the incremented address
	assign bov_target = pc_q + PC_WIDTH'(2) +
		{{(PC_WIDTH-9){fetch_word_i[7]}}, fetch_word_i[7:0], 1'b0};
	assign apb_wr = psel_i && penable_i && pready_o && pwrite_i;
	assign apb_rd_phase = psel_i && penable_i && !pready_o;

	operand_addr_resolve resolver (
		.f_i(fetch_word_i[7:0]),
		.access_i(fetch_word_i[8]),
		.ext_en_i(ext_en),
		.bank_i(bank),
		.index_base_i(index_base),
		.addr_o(res_addr),
		.indexed_o(res_indexed)
	);

	// sequencer
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			state <= ST_HALT;
		end else begin
			unique case (state)
				ST_HALT: begin
					if (run) state <= ST_FETCH;
				end
				ST_FETCH: begin
					if (!run) begin
						state <= ST_HALT;
					end else if (issue && (next_kind inside {K_TOGGLE, K_INCZ, K_INCNZ})) begin
						state <= ST_READ;
					end
				end
				ST_READ: state <= ST_WRITE;
				ST_WRITE: state <= ST_FETCH;
			endcase
		end
	end

	// decoded instruction and operand read
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			instr <= '0;
			kind_q <= K_OTHER;
			rdata <= 8'h00;
		end else begin
			if (issue) begin
				instr <= fetch_word_i;
				kind_q <= next_kind;
			end
			if (state == ST_READ) rdata <= dmem_rdata_i;
		end
	end

	// data memory port
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			dmem_o <= '0;
		end else begin
			dmem_o.we <= 1'b0;
			if (issue) dmem_o.addr <= res_addr;
			if (state == ST_WRITE) begin
				if (kind_q == K_TOGGLE) begin
					dmem_o.wdata <= rdata ^ (8'h01 << instr[11:9]);
					dmem_o.we <= 1'b1;
				end else if (instr[9]) begin
					dmem_o.wdata <= inc_result;
					dmem_o.we <= 1'b1;
				end
			end
		end
	end

	// working register; execution wins over a bus write in the same cycle
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			wreg <= WREG_RESET;
		end else if ((state == ST_WRITE) && (kind_q != K_TOGGLE) && !instr[9]) begin
			wreg <= inc_result;
		end else if (apb_wr && (paddr_i == WREG_OFFSET)) begin
			wreg <= pwdata_i[7:0];
		end
	end

	// program counter; the slot dropped after a taken branch refetches the target
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			pc_q <= '0;
		end else if (bov_taken) begin
			pc_q <= bov_target;
		end else if (take && (drop_cnt != 2'h2)) begin
			pc_q <= pc_q + PC_WIDTH'(2);
		end else if (apb_wr && (paddr_i == PC_OFFSET)) begin
			pc_q <= pwdata_i[PC_WIDTH-1:0];
		end
	end

	// discarded prefetch slots and per-instruction cycle count
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			drop_cnt <= 2'h0;
			drop_may_extend <= 1'b0;
			cyc_cur <= CYCLES_RESET;
			cyc_last <= CYCLES_RESET;
		end else begin
			if (bov_taken) begin
				drop_cnt <= 2'h2;
				drop_may_extend <= 1'b0;
			end else if ((state == ST_WRITE) && skip) begin
				drop_cnt <= 2'h1;
				drop_may_extend <= 1'b1;
			end else if (drop) begin
				if (drop_may_extend && is_two_word(fetch_word_i)) begin
					drop_cnt <= 2'h1;
				end else begin
					drop_cnt <= 2'h0;
				end
				drop_may_extend <= 1'b0;
			end
			if (issue) begin
				cyc_last <= cyc_cur;
				cyc_cur <= 2'h1;
			end else if (drop) begin
				cyc_cur <= cyc_cur + 2'h1;
			end
		end
	end

	// software registers; the flags are never touched by execution
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			run <= 1'b0;
			ext_en <= 1'b0;
			bank <= BANK_RESET;
			flags <= FLAGS_RESET;
			index_base <= INDEX_BASE_RESET;
		end else if (apb_wr) begin
			unique case (paddr_i)
				CTRL_OFFSET: begin
					run <= pwdata_i[CTRL_RUN_BIT];
					ext_en <= pwdata_i[CTRL_EXT_BIT];
				end
				BANK_OFFSET: bank <= pwdata_i[3:0];
				FLAGS_OFFSET: flags <= pwdata_i[7:0];
				INDEX_BASE_OFFSET: index_base <= pwdata_i[11:0];
				default: begin
				end
			endcase
		end
	end

	// apb answer one cycle into the access phase
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			pready_o <= 1'b0;
			prdata_o <= 32'h0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= apb_rd_phase;
			pslverr_o <= 1'b0;
			if (apb_rd_phase) begin
				prdata_o <= 32'h0;
				unique case (paddr_i)
					CTRL_OFFSET: prdata_o <= {30'h0, ext_en, run};
					BANK_OFFSET: prdata_o <= {28'h0, bank};
					FLAGS_OFFSET: prdata_o <= {24'h0, flags};
					WREG_OFFSET: prdata_o <= {24'h0, wreg};
					PC_OFFSET: prdata_o <= 32'(pc_q);
					INDEX_BASE_OFFSET: prdata_o <= {20'h0, index_base};
					CYCLES_OFFSET: prdata_o <= {30'h0, cyc_last};
					default: pslverr_o <= 1'b1;
				endcase
			end
		end
	end

	toggle_invert_a: assert property ((state == ST_WRITE) && (kind_q == K_TOGGLE) |=>
		dmem_o.we && (dmem_o.wdata == (rdata ^ (8'h01 << instr[11:9]))))
		else $error("toggle wrote wrong value");
	flags_untouched_a: assert property (!(apb_wr && (paddr_i == FLAGS_OFFSET)) |=>
		$stable(flags))
		else $error("status flags changed by execution");
	branch_target_a: assert property (bov_taken |=> (pc_q == $past(bov_target)))
		else $error("branch target wrong");
	branch_decode_a: assert property (issue && (fetch_word_i[15:8] == 8'he4) |=>
		(kind_q == K_BOV))
		else $error("branch not decoded");
	inc_dest_a: assert property ((state == ST_WRITE) && (kind_q inside {K_INCZ, K_INCNZ})
		|=> (instr[9] ? (dmem_o.we && dmem_o.wdata == rdata + 8'h01) :
		(!dmem_o.we && wreg == rdata + 8'h01)))
		else $error("increment destination wrong");
	skip_zero_a: assert property ((state == ST_WRITE) && (kind_q == K_INCZ) &&
		(rdata == 8'hff) |=> (drop_cnt == 2'h1) ##0 drop_may_extend)
		else $error("zero skip missing");
	skip_nonzero_a: assert property ((state == ST_WRITE) && (kind_q == K_INCNZ) &&
		(rdata != 8'hff) |=> (drop_cnt == 2'h1))
		else $error("nonzero skip missing");
	indexed_addr_a: assert property (issue && ext_en && !fetch_word_i[8] &&
		(fetch_word_i[7:0] <= 8'h5f) && (next_kind != K_BOV) |=>
		(dmem_o.addr == $past(index_base) + {4'h0, $past(fetch_word_i[7:0])}))
		else $error("indexed address wrong");
	ext_gate_a: assert property (!ext_en |-> !res_indexed)
		else $error("indexed mode without extended set");
	skip_two_word_a: assert property (drop && drop_may_extend && is_two_word(fetch_word_i)
		|=> (drop_cnt == 2'h1) && !drop_may_extend && (cyc_cur == 2'h2))
		else $error("two-word skip not extended");
	branch_cycles_a: assert property (issue && (next_kind == K_BOV) |=>
		(drop_cnt == ($past(flags[FLAG_OV_BIT]) ? 2'h2 : 2'h0)))
		else $error("branch cycle count wrong");

	toggle_seen_c: cover property ((state == ST_WRITE) && (kind_q == K_TOGGLE));
	skip_seen_c: cover property ((state == ST_WRITE) && skip);
	branch_seen_c: cover property (bov_taken);
	long_skip_c: cover property (issue && (cyc_cur == 2'h3));
endmodule
`default_nettype wire

// ===== dv/fetch_far_model.sv
// program and data memory model on the far side of the execute block
`timescale 1ns/1ps
`default_nettype none
module fetch_far_model (
	// control
	input wire logic clk_i,
	input wire logic stall_i,
	// fetch side
	input wire logic [9:0] pc_i,
	output logic valid_o,
	output logic [bit_toggle_branch_skip_pkg::WORD_W-1:0] word_o,
	// data side
	input wire bit_toggle_branch_skip_pkg::dmem_req_type dmem_i,
	output logic [bit_toggle_branch_skip_pkg::DATA_W-1:0] rdata_o
);
	import bit_toggle_branch_skip_pkg::*;
	logic [WORD_W-1:0] pmem [512];
	logic [DATA_W-1:0] dmem [4096];
	assign valid_o = !stall_i;
	// a stalled slot shows garbage, not the held word
	assign word_o = stall_i ? ~pmem[pc_i[9:1]] : pmem[pc_i[9:1]];
	assign rdata_o = dmem[dmem_i.addr];
	always @(posedge clk_i) begin
		if (dmem_i.we === 1'b1) begin
			dmem[dmem_i.addr] <= dmem_i.wdata;
		end
	end
endmodule
`default_nettype wire

// ===== dv/bit_toggle_branch_skip_exec_tb_top.sv
// self-checking bench for the toggle, branch and skip execute block
`timescale 1ns/1ps
`default_nettype none
module bit_toggle_branch_skip_exec_tb_top;
	import bit_toggle_branch_skip_pkg::*;
	logic clk, rst, psel, pen, pwr, prdy, perr, fvalid, frdy, stall, e0;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [WORD_W-1:0] fword;
	logic [9:0] pc;
	dmem_req_type dreq;
	logic [DATA_W-1:0] drd;
	int bad_count, cmp_count;
	bit_toggle_branch_skip_exec #(.PC_WIDTH(10)) i_bit_toggle_branch_skip_exec (
		.core_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(prdy), .pslverr_o(perr), .fetch_valid_i(fvalid),
		.fetch_word_i(fword), .fetch_ready_o(frdy), .pc_o(pc), .dmem_o(dreq),
		.dmem_rdata_i(drd)
	);
	fetch_far_model i_far (
		.clk_i(clk), .stall_i(stall), .pc_i(pc), .valid_o(fvalid), .word_o(fword),
		.dmem_i(dreq), .rdata_o(drd)
	);
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x) begin
			bad_count++;
			$display("mismatch t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (prdy !== 1'b1);
		r = prdata;
		e0 = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#40000;
		bad_count++;
		final_report();
	end
	initial begin
		int op, b, ext, bk, ib, a, d, tw, n, t;
		logic [7:0] f, v, fl, w, res, e, ew, ea, eb;
		logic skip;
		rst = 1'b1;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = '0;
		pwdata = '0;
		stall = 1'b0;
		void'($urandom(32'hdcd1c97b));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, WREG_OFFSET, 0);
		chk(r, WREG_RESET);
		apb(1'b0, 12'h01c, 0);
		chk(r, 32'h0);
		chk({31'h0, e0}, 32'h1);
		for (int it = 0; it < 40; it++) begin
			op = $urandom % 4;
			f = 8'($urandom % 240);
			b = $urandom % 8;
			ext = $urandom % 2;
			a = $urandom % 2;
			d = $urandom % 2;
			tw = $urandom % 2;
			bk = 8 + $urandom % 7;
			ib = $urandom % 2048;
			n = 40 + $urandom % 88;
			if ($urandom % 2) n = -n - 1;
			fl = 8'($urandom);
			w = 8'($urandom);
			v = ($urandom % 2) ? 8'hff : 8'($urandom);
			for (int i = 0; i < 512; i++) i_far.pmem[i] = '0;
			t = a ? {bk[3:0], f} : (ext && f <= INDEXED_F_MAX) ? ib + f :
				(f < ACCESS_SPLIT) ? f : 12'hf00 | f;
			i_far.pmem[0] = op == 0 ? {TOGGLE_PATTERN, b[2:0], a[0], f} :
				op == 3 ? {OVF_BRANCH_PATTERN, n[7:0]} :
				{op == 1 ? INC_SKIP_Z_PATTERN : INC_SKIP_NZ_PATTERN, d[0], a[0], f};
			// markers: toggle bit 0 of two spare registers in the selected bank
			i_far.pmem[1] = tw ? 16'hc000 : 16'h71f0;
			i_far.pmem[2] = tw ? 16'h71f0 : 16'h0000;
			i_far.pmem[(n + 1) & 511] = 16'h71f1;
			i_far.dmem[t] = v;
			i_far.dmem[{bk[3:0], 8'hf0}] = 8'h00;
			i_far.dmem[{bk[3:0], 8'hf1}] = 8'h00;
			res = v + 8'h01;
			e = v;
			ew = w;
			eb = 8'h00;
			skip = (op == 1 && res == 0) || (op == 2 && res != 0);
			if (op == 0) e = v ^ (8'h01 << b);
			if ((op == 1 || op == 2) && d) e = res;
			if ((op == 1 || op == 2) && !d) ew = res;
			if (op == 3 && fl[FLAG_OV_BIT]) begin
				skip = 1'b1;
				eb = 8'h01;
			end
			ea = {7'h0, !skip};
			apb(1'b1, CTRL_OFFSET, ext << CTRL_EXT_BIT);
			apb(1'b1, BANK_OFFSET, bk);
			apb(1'b1, FLAGS_OFFSET, fl);
			apb(1'b1, WREG_OFFSET, w);
			apb(1'b1, PC_OFFSET, 0);
			apb(1'b1, INDEX_BASE_OFFSET, ib);
			apb(1'b1, CTRL_OFFSET, (ext << CTRL_EXT_BIT) | 1);
			repeat (30) begin
				stall <= ($urandom % 8) == 0;
				@(posedge clk);
			end
			stall <= 1'b0;
			apb(1'b1, CTRL_OFFSET, ext << CTRL_EXT_BIT);
			apb(1'b0, FLAGS_OFFSET, 0);
			chk(r, fl);
			apb(1'b0, WREG_OFFSET, 0);
			chk(r, ew);
			chk(i_far.dmem[t], e);
			chk(i_far.dmem[{bk[3:0], 8'hf0}], ea);
			chk(i_far.dmem[{bk[3:0], 8'hf1}], eb);
			apb(1'b0, CYCLES_OFFSET, 0);
			chk(r, 32'h1);
			chk({31'h0, frdy}, 32'h0);
		end
		final_report();
	end
endmodule
`default_nettype wire
